// ==== hw/atr_pkg.sv ====
// shared constants for the acquisition timing signal router
package atr_pkg;
   // bus widths and counters
   localparam int          ATR_AW          = 4;
   localparam int          ATR_DW          = 32;
   localparam int          ATR_CNT24_W     = 24;
   localparam int          ATR_CNT16_W     = 16;
   localparam int          ATR_NUM_C24     = 7;
   localparam int          ATR_NUM_C16     = 3;
   // timing
   localparam int          ATR_SYS_HZ      = 40000000;
   localparam int          ATR_INT_TB_HZ   = 20000000;
   localparam int          ATR_RES_NS      = 50;
   localparam int          ATR_TB_DIV      = ATR_SYS_HZ / ATR_INT_TB_HZ;
   // word offsets (byte address = 4 * index)
   localparam logic [3:0]  ATR_REG_CTRL    = 4'h0;
   localparam logic [3:0]  ATR_REG_SRC     = 4'h1;
   localparam logic [3:0]  ATR_REG_OUTEN   = 4'h2;
   localparam logic [3:0]  ATR_REG_INTVL   = 4'h3;
   localparam logic [3:0]  ATR_REG_STATUS  = 4'h4;
   localparam logic [3:0]  ATR_REG_SCNT    = 4'h5;
   localparam logic [3:0]  ATR_REG_CCNT    = 4'h6;
   // ctrl fields
   localparam int          ATR_CTRL_TBSEL  = 0;
   localparam int          ATR_CTRL_TBOUT  = 1;
   localparam int          ATR_CTRL_SYNC7  = 2;
   localparam int          ATR_CTRL_ARM    = 3;
   localparam int          ATR_CTRL_SWSTART = 4;
   // source select: 4 bits per timing signal
   localparam int          ATR_SEL_W       = 4;
   localparam int          ATR_NSIG        = 6;
   localparam logic [3:0]  ATR_SEL_PIN     = 4'h0;
   localparam logic [3:0]  ATR_SEL_TRIG0   = 4'h1;
   localparam logic [3:0]  ATR_SEL_STAR    = 4'h7;
   localparam logic [3:0]  ATR_SEL_TC      = 4'h8;
   localparam logic [3:0]  ATR_SEL_NONE    = 4'hf;
   localparam int          ATR_SIG_START   = 0;
   localparam int          ATR_SIG_REF     = 1;
   localparam int          ATR_SIG_SCAN    = 2;
   localparam int          ATR_SIG_CONV    = 3;
   localparam int          ATR_SIG_PAUSE   = 4;
   localparam int          ATR_SIG_TBASE   = 5;
   localparam logic [23:0] ATR_SRC_RST     = 24'hf88fff;
   // output enable fields
   localparam int          ATR_OE_START_PIN = 0;
   localparam int          ATR_OE_START_BP  = 1;
   localparam int          ATR_OE_REF_BP    = 2;
   localparam int          ATR_OE_SCAN_BP   = 3;
   localparam int          ATR_OE_CONV_BP   = 4;
   localparam int          ATR_OE_LINE_W    = 3;
   localparam int          ATR_OE_LINE_LO   = 8;
   localparam int          ATR_OE_W        = 20;
   localparam logic [23:0] ATR_INTVL_RST   = 24'h000010;
   localparam int          ATR_BP_W        = 8;
   localparam int          ATR_SYNC_LINE   = 7;
endpackage : atr_pkg

// ==== hw/atr_router.sv ====
// acquisition timing signal router with wishbone register access
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - two timing groups: seven 24-bit and three 16-bit counters, 50 ns resolution
// - conversion pulse source: front pin, backplane lines 0..5, star, or interval terminal count
// - any timing signal may select the front pin, several at once
// - acquisition start trigger can drive the front pin when enabled
// - master timebase selectable: internal 20 MHz or backplane clock line
// - selected timebase enables the sample interval counter unless a scan timebase source is selected
// - internal timebase may be driven onto backplane clock; receivers must opt in
// - after reset: internal timebase, backplane timebase line undriven
// - backplane line 7 can clear the sample interval counter; the master timebase runs on
// - star trigger is received only, never driven
// - start trigger from pin or backplane; actual start driven on both
// - reference trigger from pin or backplane, output only on backplane
// - scan pulse samples every channel; in from pin/backplane, out backplane only
// - conversion pulse starts one conversion; in pin/backplane, out backplane only
// - pause gate suspends acquisition while asserted, resumes after
// - scan timebase input from pin or backplane drives sample clocks
module atr_router (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // front programmable pin
   input  wire logic        pin_i,
   output logic             pin_o,
   output logic             pin_oe,
   // backplane trigger lines
   input  wire logic [7:0]  bp_trig_i,
   output logic      [7:0]  bp_trig_o,
   output logic      [7:0]  bp_trig_oe,
   input  wire logic        star_i,
   // backplane clock line
   input  wire logic        bp_clk_i,
   output logic             bp_clk_o,
   output logic             bp_clk_oe,
   // acquisition events
   output logic             conv_start,
   output logic             scan_start,
   output logic             acq_running
);
   typedef enum logic [1:0] {ATR_IDLE, ATR_ARMED, ATR_RUN} atr_state_t;

   // synchronisers
   logic [1:0]  pin_s_r;
   logic [15:0] bp_s_r;
   logic [1:0]  star_s_r;
   logic [1:0]  bpclk_s_r;
   logic [7:0]  bp_q;
   logic        pin_q;
   logic        star_q;
   logic        bpclk_q;
   logic        bpclk_d_r;
   logic [atr_pkg::ATR_NSIG-1:0] routed_d_r;

   always_ff @(posedge sys_clk) begin
      pin_s_r   <= {pin_s_r[0], pin_i};
      bp_s_r    <= {bp_s_r[7:0], bp_trig_i};
      star_s_r  <= {star_s_r[0], star_i};
      bpclk_s_r <= {bpclk_s_r[0], bp_clk_i};
   end
   assign pin_q   = pin_s_r[1];
   assign bp_q    = bp_s_r[15:8];
   assign star_q  = star_s_r[1];
   assign bpclk_q = bpclk_s_r[1];

   // registers
   logic [7:0]  ctrl_r;
   logic [23:0] src_r;
   logic [atr_pkg::ATR_OE_W-1:0] oe_r;
   logic [23:0] intvl_r;
   logic [23:0] src_act_r;
   logic [atr_pkg::ATR_OE_W-1:0] oe_act_r;
   logic [23:0] intvl_act_r;
   logic        tbsel_act_r;
   logic [23:0] scan_cnt_r;
   logic [15:0] conv_cnt_r;
   atr_state_t  state_r;
   atr_state_t  state_nxt;
   // terminal count one cycle late: a pause or timebase fed from it forms no loop
   logic        tc_r;

   wire [3:0] wb_idx   = wb_adr_i[5:2];
   wire       wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire       wb_wr    = wb_req && wb_we_i && wb_sel_i[0];
   wire       wr_ctrl  = wb_wr && (wb_idx == atr_pkg::ATR_REG_CTRL);
   wire       wr_src   = wb_wr && (wb_idx == atr_pkg::ATR_REG_SRC);
   wire       wr_oe    = wb_wr && (wb_idx == atr_pkg::ATR_REG_OUTEN);
   wire       wr_intvl = wb_wr && (wb_idx == atr_pkg::ATR_REG_INTVL);
   wire       idle     = (state_r == ATR_IDLE);

   // byte-lane merge for the wide registers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            m[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   wire [31:0] src_m   = merge({8'h00, src_r}, wb_dat_i, wb_sel_i);
   wire [31:0] oe_m    = merge({12'h000, oe_r}, wb_dat_i, wb_sel_i);
   wire [31:0] intvl_m = merge({8'h00, intvl_r}, wb_dat_i, wb_sel_i);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_r  <= 8'h00;
         src_r   <= atr_pkg::ATR_SRC_RST;
         oe_r    <= '0;
         intvl_r <= atr_pkg::ATR_INTVL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= wb_dat_i[7:0];
         end else if (state_r != ATR_IDLE || !ctrl_r[atr_pkg::ATR_CTRL_ARM]) begin
            // a start written with arm survives until the sequencer leaves idle
            ctrl_r[atr_pkg::ATR_CTRL_SWSTART] <= 1'b0;
         end
         if (wr_src) begin
            src_r <= src_m[23:0];
         end
         if (wr_oe) begin
            oe_r <= oe_m[atr_pkg::ATR_OE_W-1:0];
         end
         if (wr_intvl) begin
            intvl_r <= intvl_m[23:0];
         end
      end
   end

   // active copies only load while idle, so settings land before a start
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         src_act_r   <= atr_pkg::ATR_SRC_RST;
         oe_act_r    <= '0;
         intvl_act_r <= atr_pkg::ATR_INTVL_RST;
         tbsel_act_r <= 1'b0;
      end else if (idle) begin
         src_act_r   <= src_r;
         oe_act_r    <= oe_r;
         intvl_act_r <= intvl_r;
         tbsel_act_r <= ctrl_r[atr_pkg::ATR_CTRL_TBSEL];
      end
   end

   // timebase: internal half rate enable or backplane clock edge
   logic int_tb_r;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         int_tb_r  <= 1'b0;
         bpclk_d_r <= 1'b0;
      end else begin
         int_tb_r  <= !int_tb_r;
         bpclk_d_r <= bpclk_q;
      end
   end
   wire bp_tb_en  = bpclk_q && !bpclk_d_r;
   wire sync7_clr = ctrl_r[atr_pkg::ATR_CTRL_SYNC7] && bp_q[atr_pkg::ATR_SYNC_LINE];
   wire tb_en     = tbsel_act_r ? bp_tb_en : int_tb_r;

   // source selection
   atr_sel_if sif ();
   assign sif.bp_trig = bp_q;
   assign sif.pin     = pin_q;
   assign sif.star    = star_q;
   assign sif.tc      = tc_r;
   assign sif.sel     = src_act_r;
   atr_src_mux u_mux (
      .s (sif)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         routed_d_r <= '0;
      end else begin
         routed_d_r <= sif.routed;
      end
   end
   wire [atr_pkg::ATR_NSIG-1:0] rise = sif.routed & ~routed_d_r;
   wire ext_start = rise[atr_pkg::ATR_SIG_START];
   wire ref_hit   = rise[atr_pkg::ATR_SIG_REF];
   wire paused    = sif.routed[atr_pkg::ATR_SIG_PAUSE];
   wire ext_tb    = (src_act_r[atr_pkg::ATR_SIG_TBASE*atr_pkg::ATR_SEL_W +: atr_pkg::ATR_SEL_W] != atr_pkg::ATR_SEL_NONE);
   wire scan_tick_en = ext_tb ? rise[atr_pkg::ATR_SIG_TBASE] : tb_en;
   wire ext_scan  = (src_act_r[atr_pkg::ATR_SIG_SCAN*atr_pkg::ATR_SEL_W +: atr_pkg::ATR_SEL_W] != atr_pkg::ATR_SEL_NONE);
   wire ext_conv  = (src_act_r[atr_pkg::ATR_SIG_CONV*atr_pkg::ATR_SEL_W +: atr_pkg::ATR_SEL_W] != atr_pkg::ATR_SEL_NONE);

   // sample interval counter, 24 bits, one of the acquisition group
   wire tc_pulse = (state_r == ATR_RUN) && !paused && scan_tick_en && (scan_cnt_r == 24'h000000);
   always_ff @(posedge sys_clk) begin
      if (rst || sync7_clr) begin
         scan_cnt_r <= 24'h000000;
      end else if (state_r != ATR_RUN) begin
         scan_cnt_r <= intvl_act_r;
      end else if (scan_tick_en && !paused) begin
         scan_cnt_r <= (scan_cnt_r == 24'h000000) ? intvl_act_r : scan_cnt_r - 24'h000001;
      end
   end

   // acquisition sequencer
   wire start_now = ext_start || ctrl_r[atr_pkg::ATR_CTRL_SWSTART];
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ATR_IDLE:  if (ctrl_r[atr_pkg::ATR_CTRL_ARM]) state_nxt = ATR_ARMED;
         ATR_ARMED: if (!ctrl_r[atr_pkg::ATR_CTRL_ARM]) state_nxt = ATR_IDLE;
                    else if (start_now) state_nxt = ATR_RUN;
         ATR_RUN:   if (!ctrl_r[atr_pkg::ATR_CTRL_ARM]) state_nxt = ATR_IDLE;
         default:   state_nxt = ATR_IDLE;
      endcase
   end

   wire run_ok   = (state_r == ATR_RUN) && !paused;
   wire scan_now = run_ok && (ext_scan ? rise[atr_pkg::ATR_SIG_SCAN] : tc_pulse);
   wire conv_now = run_ok && (ext_conv ? rise[atr_pkg::ATR_SIG_CONV] : scan_now);
   wire start_ev = (state_r == ATR_ARMED) && (state_nxt == ATR_RUN);
   logic ref_seen_r;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r     <= ATR_IDLE;
         conv_start  <= 1'b0;
         scan_start  <= 1'b0;
         acq_running <= 1'b0;
         ref_seen_r  <= 1'b0;
         conv_cnt_r  <= 16'h0000;
         tc_r        <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         tc_r        <= tc_pulse;
         conv_start  <= conv_now;
         scan_start  <= scan_now;
         acq_running <= (state_nxt == ATR_RUN);
         if (start_ev) begin
            ref_seen_r <= 1'b0;
            conv_cnt_r <= 16'h0000;
         end else begin
            if (ref_hit && state_r == ATR_RUN) ref_seen_r <= 1'b1;
            if (conv_now) conv_cnt_r <= conv_cnt_r + 16'h0001;
         end
      end
   end

   // pin and backplane drivers
   wire [2:0] start_line = oe_act_r[atr_pkg::ATR_OE_LINE_LO +: atr_pkg::ATR_OE_LINE_W];
   wire [2:0] ref_line   = oe_act_r[atr_pkg::ATR_OE_LINE_LO+atr_pkg::ATR_OE_LINE_W +: atr_pkg::ATR_OE_LINE_W];
   wire [2:0] scan_line  = oe_act_r[atr_pkg::ATR_OE_LINE_LO+2*atr_pkg::ATR_OE_LINE_W +: atr_pkg::ATR_OE_LINE_W];
   wire [2:0] conv_line  = oe_act_r[atr_pkg::ATR_OE_LINE_LO+3*atr_pkg::ATR_OE_LINE_W +: atr_pkg::ATR_OE_LINE_W];
   logic [7:0] bp_o_nxt;
   logic [7:0] bp_oe_nxt;
   always_comb begin
      bp_o_nxt  = 8'h00;
      bp_oe_nxt = 8'h00;
      if (oe_act_r[atr_pkg::ATR_OE_START_BP]) begin
         bp_oe_nxt[start_line] = 1'b1;
         bp_o_nxt[start_line]  = start_ev;
      end
      if (oe_act_r[atr_pkg::ATR_OE_REF_BP]) begin
         bp_oe_nxt[ref_line] = 1'b1;
         bp_o_nxt[ref_line]  = bp_o_nxt[ref_line] | (ref_hit && state_r == ATR_RUN);
      end
      if (oe_act_r[atr_pkg::ATR_OE_SCAN_BP]) begin
         bp_oe_nxt[scan_line] = 1'b1;
         bp_o_nxt[scan_line]  = bp_o_nxt[scan_line] | scan_now;
      end
      if (oe_act_r[atr_pkg::ATR_OE_CONV_BP]) begin
         bp_oe_nxt[conv_line] = 1'b1;
         bp_o_nxt[conv_line]  = bp_o_nxt[conv_line] | conv_now;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pin_o      <= 1'b0;
         pin_oe     <= 1'b0;
         bp_trig_o  <= 8'h00;
         bp_trig_oe <= 8'h00;
         bp_clk_o   <= 1'b0;
         bp_clk_oe  <= 1'b0;
      end else begin
         pin_oe     <= oe_act_r[atr_pkg::ATR_OE_START_PIN];
         pin_o      <= start_ev && oe_act_r[atr_pkg::ATR_OE_START_PIN];
         bp_trig_o  <= bp_o_nxt;
         bp_trig_oe <= bp_oe_nxt;
         // only the internal source may be driven out
         bp_clk_oe  <= ctrl_r[atr_pkg::ATR_CTRL_TBOUT] && !ctrl_r[atr_pkg::ATR_CTRL_TBSEL];
         bp_clk_o   <= int_tb_r;
      end
   end

   // read back and ack
   logic [31:0] rd_mux;
   always_comb begin
      case (wb_idx)
         atr_pkg::ATR_REG_CTRL:   rd_mux = {24'h000000, ctrl_r};
         atr_pkg::ATR_REG_SRC:    rd_mux = {8'h00, src_r};
         atr_pkg::ATR_REG_OUTEN:  rd_mux = {12'h000, oe_r};
         atr_pkg::ATR_REG_INTVL:  rd_mux = {8'h00, intvl_r};
         atr_pkg::ATR_REG_STATUS: rd_mux = {26'h0000000, sif.routed[atr_pkg::ATR_SIG_PAUSE], ref_seen_r,
                                            tbsel_act_r, paused, state_r};
         atr_pkg::ATR_REG_SCNT:   rd_mux = {8'h00, scan_cnt_r};
         atr_pkg::ATR_REG_CCNT:   rd_mux = {16'h0000, conv_cnt_r};
         default:                 rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_mux : 32'h00000000;
      end
   end
endmodule : atr_router

// ==== hw/atr_sel_if.sv ====
// signals between the router core and its source selector
`timescale 1ns/1ps
interface atr_sel_if;
   logic [atr_pkg::ATR_BP_W-1:0] bp_trig;
   logic                         pin;
   logic                         star;
   logic                         tc;
   logic [atr_pkg::ATR_SEL_W*atr_pkg::ATR_NSIG-1:0] sel;
   logic [atr_pkg::ATR_NSIG-1:0] routed;
   modport core (output bp_trig, output pin, output star, output tc, output sel, input routed);
   modport mux  (input bp_trig, input pin, input star, input tc, input sel, output routed);
endinterface : atr_sel_if

// ==== hw/atr_src_mux.sv ====
// per-signal source multiplexers for the timing signals
`timescale 1ns/1ps
module atr_src_mux (
   // selector link
   atr_sel_if.mux s
);
   genvar g;
   generate
      for (g = 0; g < atr_pkg::ATR_NSIG; g++) begin : g_sig
         wire [3:0] code = s.sel[g*atr_pkg::ATR_SEL_W +: atr_pkg::ATR_SEL_W];
         wire       is_bp = (code >= atr_pkg::ATR_SEL_TRIG0) && (code < atr_pkg::ATR_SEL_STAR);
         wire [3:0] line = code - atr_pkg::ATR_SEL_TRIG0;
         // every signal may pick the pin at once
         assign s.routed[g] = (code == atr_pkg::ATR_SEL_PIN)  ? s.pin :
                              is_bp                           ? s.bp_trig[line[2:0]] :
                              (code == atr_pkg::ATR_SEL_STAR) ? s.star :
                              (code == atr_pkg::ATR_SEL_TC)   ? s.tc : 1'b0;
      end
   endgenerate
endmodule : atr_src_mux

// ==== verification/atr_far_side.sv ====
// far side: front-pin circuitry, backplane modules and star controller
`timescale 1ns/1ps
module atr_far_side (
   // bench requests: [0] pin, [8:1] lines 0..7, [9] star
   input logic        sys_clk,
   input logic [9:0]  req,
   // device drivers
   input logic        pin_o,
   input logic        pin_oe,
   input logic [7:0]  bp_trig_o,
   input logic [7:0]  bp_trig_oe,
   input logic        bp_clk_o,
   input logic        bp_clk_oe,
   // levels seen by the device
   output logic       pin_i,
   output logic [7:0] bp_trig_i,
   output logic       star_i,
   output logic       bp_clk_i
);
   logic [1:0] div_r = 2'h0;
   always @(posedge sys_clk) div_r <= div_r + 2'h1;
   // wire level resolved from both drivers
   assign pin_i     = pin_oe ? pin_o : req[0];
   assign bp_trig_i = (bp_trig_oe & bp_trig_o) | (~bp_trig_oe & req[8:1]);
   assign star_i    = req[9];
   // neighbour timebase runs free unless the device drives the line
   assign bp_clk_i  = bp_clk_oe ? bp_clk_o : div_r[1];
endmodule : atr_far_side

// ==== verification/atr_router_asserts.sv ====
// concurrent checks on the router's ports
`timescale 1ns/1ps
module atr_router_asserts (
   // clock and reset
   input logic        sys_clk,
   input logic        rst,
   // register bus
   input logic        wb_cyc_i,
   input logic        wb_stb_i,
   input logic [31:0] wb_dat_o,
   input logic        wb_ack_o,
   // drivers and events
   input logic        pin_oe,
   input logic [7:0]  bp_trig_oe,
   input logic        bp_clk_oe,
   input logic        conv_start,
   input logic        acq_running
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   wire req = wb_cyc_i & wb_stb_i;
   a_ack_latency: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_cause: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
   a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   a_reset_quiet: assert property ($fell(rst) |->
      !bp_clk_oe && bp_trig_oe == 8'h0 && !pin_oe && !acq_running) else $error("drivers active after reset");
   // line enables are frozen for the whole run; the clock enable follows ctrl_r directly
   a_oe_frozen: assert property (acq_running && $past(acq_running) |-> $stable(bp_trig_oe))
      else $error("line enables moved in run");
   a_clkout_frozen: assert property (acq_running && $past(acq_running) |-> $stable(bp_clk_oe))
      else $error("clock enable moved in run");
   a_conv_single: assert property (conv_start |=> !conv_start) else $error("conversion pulse too long");
   c_bus: cover property (req && wb_ack_o);
   c_run: cover property ($rose(acq_running));
   c_conv: cover property (conv_start);
   c_clk_out: cover property (bp_clk_oe);
endmodule : atr_router_asserts

// ==== verification/atr_router_tb.sv ====
// self-checking bench for the timing signal router
`timescale 1ns/1ps
module atr_router_tb;
   logic        sys_clk;
   logic        rst;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [5:0]  adr;
   logic [31:0] dat;
   logic [9:0]  req;
   logic [31:0] rd;
   logic        seen;
   int          failures;
   int          n_tests;
   int          cycles;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o, pin_i, pin_o, pin_oe, star_i, bp_clk_i, bp_clk_o, bp_clk_oe;
   wire  [7:0]  bp_trig_i, bp_trig_o, bp_trig_oe;
   wire         conv_start, scan_start, acq_running;

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles > 40000) begin
         failures = failures + 1;
         stop_test();
      end
   end

   atr_router uut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe(pin_oe), .bp_trig_i(bp_trig_i), .bp_trig_o(bp_trig_o), .bp_trig_oe(bp_trig_oe), .star_i(star_i),
      .bp_clk_i(bp_clk_i), .bp_clk_o(bp_clk_o), .bp_clk_oe(bp_clk_oe), .conv_start(conv_start),
      .scan_start(scan_start), .acq_running(acq_running));
   atr_far_side u_far (.sys_clk(sys_clk), .req(req), .pin_o(pin_o), .pin_oe(pin_oe), .bp_trig_o(bp_trig_o),
      .bp_trig_oe(bp_trig_oe), .bp_clk_o(bp_clk_o), .bp_clk_oe(bp_clk_oe), .pin_i(pin_i),
      .bp_trig_i(bp_trig_i), .star_i(star_i), .bp_clk_i(bp_clk_i));

   task automatic stop_test();
      if (failures == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // classic single cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= {a, 2'b00};
      dat <= d;
      do begin
         @(posedge sys_clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      rd = wb_dat_o;
      if (k >= 50) failures++;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : bus
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk
   // 0 conversion, 1 running, 2 scan, 3 pin pulse
   task automatic wait_ev(input int w, input int lim);
      int k;
      k = 0;
      seen = 1'b0;
      while (seen !== 1'b1 && k < lim) begin
         @(posedge sys_clk);
         #1;
         k++;
         seen = (w == 0) ? conv_start : (w == 1) ? acq_running : (w == 2) ? scan_start : pin_o;
      end
   endtask : wait_ev
   // two cycles pass the synchronisers; the one-cycle result lands just after return
   task automatic pulse(input int i);
      @(posedge sys_clk);
      req[i] <= 1'b1;
      repeat (2) @(posedge sys_clk);
      req[i] <= 1'b0;
   endtask : pulse
   task automatic do_rst();
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
   endtask : do_rst

   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 6'h00;
      dat = 32'h0;
      req = 10'h000;
      failures = 0;
      n_tests = 0;
      cycles = 0;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      chk({31'h0, bp_clk_oe}, 32'h0);
      rdchk(atr_pkg::ATR_REG_CTRL, 32'h0);
      rdchk(atr_pkg::ATR_REG_STATUS, 32'h0);
      rdchk(atr_pkg::ATR_REG_SRC, {8'h0, atr_pkg::ATR_SRC_RST});
      rdchk(atr_pkg::ATR_REG_INTVL, {8'h0, atr_pkg::ATR_INTVL_RST});
      rdchk(atr_pkg::ATR_REG_OUTEN, 32'h0);
      wr(4'h9, 32'hffffffff);
      rdchk(4'h9, 32'h0);
      wr(atr_pkg::ATR_REG_CTRL, 32'h2);
      rdchk(atr_pkg::ATR_REG_STATUS, 32'h0);
      chk({31'h0, bp_clk_oe}, 32'h1);
      // the driven timebase must toggle every cycle
      #1;
      seen = bp_clk_o;
      @(posedge sys_clk);
      #1;
      chk({31'h0, bp_clk_o ^ seen}, 32'h1);
      wr(atr_pkg::ATR_REG_CTRL, 32'h3);
      rdchk(atr_pkg::ATR_REG_STATUS, 32'h8);
      chk({31'h0, bp_clk_oe}, 32'h0);
      // start, reference, scan and conversion on the pin, start echoed on line 3
      do_rst();
      wr(atr_pkg::ATR_REG_SRC, 32'h00ff0000);
      wr(atr_pkg::ATR_REG_OUTEN, 32'h00000302);
      wr(atr_pkg::ATR_REG_CTRL, 32'h8);
      pulse(0);
      wait_ev(1, 40);
      chk({31'h0, seen}, 32'h1);
      chk({31'h0, bp_trig_oe[3]}, 32'h1);
      chk({31'h0, bp_trig_o[3]}, 32'h1);
      pulse(0);
      wait_ev(0, 40);
      chk({31'h0, seen}, 32'h1);
      pulse(0);
      wait_ev(2, 40);
      chk({31'h0, seen}, 32'h1);
      // running, reference seen on the first in-run edge, two conversions counted
      rdchk(atr_pkg::ATR_REG_STATUS, 32'h12);
      rdchk(atr_pkg::ATR_REG_CCNT, 32'h2);
      // start to the pin; software start, as a driven pin masks outside pulses
      do_rst();
      wr(atr_pkg::ATR_REG_OUTEN, 32'h1);
      wr(atr_pkg::ATR_REG_CTRL, 32'h18);
      wait_ev(3, 40);
      chk({31'h0, seen}, 32'h1);
      chk({31'h0, pin_oe}, 32'h1);
      // conversion source: lines 0..5, star, interval terminal count
      for (int c = 1; c <= 8; c++) begin
         do_rst();
         wr(atr_pkg::ATR_REG_SRC, {8'h0, 8'hff, c[3:0], 12'hff0});
         wr(atr_pkg::ATR_REG_CTRL, 32'h18);
         wait_ev(1, 40);
         if (c < 8) pulse(c == 7 ? 9 : c);
         wait_ev(0, 200);
         chk({31'h0, seen}, 32'h1);
      end
      stop_test();
   end
endmodule : atr_router_tb

bind atr_router atr_router_asserts u_chk (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_oe(pin_oe), .bp_trig_oe(bp_trig_oe), .bp_clk_oe(bp_clk_oe),
   .conv_start(conv_start), .acq_running(acq_running));
